// *** testbench/tb.sv ***
// Self-checking bench: Wishbone traffic through the controller into the device end.
`timescale 1ns/1ps
`include "xpp_cfg.svh"
module tb;
    logic        clk_i;     // System clock.
    logic        rst_i;     // Reset of both ends.
    logic        cyc, stb;  // Wishbone cycle and strobe.
    logic        we;        // Wishbone write enable.
    logic [7:0]  adr;       // Wishbone address.
    logic [31:0] wdat;      // Wishbone write data.
    logic [3:0]  sel;       // Wishbone byte enables, raised with the request.
    logic [31:0] dat_o;     // Wishbone read data.
    logic        ack_o;     // Wishbone acknowledge.
    logic [7:0]  route_en;  // Per-output enables.
    logic [23:0] route_src; // Per-output sources.
    logic [31:0] r, w1, w2, ex;
    logic [7:0]  pv[2];
    int          err_count, tests_run;

    xpp_link_if link();
    xpp_host xpp_host_inst (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc), .stb_i(stb), .we_i(we),
        .adr_i(adr), .sel_i(sel), .dat_i(wdat), .dat_o(dat_o), .ack_o(ack_o), .link(link));
    xpp_dev xpp_dev_inst (.rst_i(rst_i), .link(link), .route_enable_o(route_en),
        .route_source_o(route_src));
    xpp_link_monitor xpp_link_monitor_inst (.clk_i(clk_i), .rst_i(rst_i),
        .prog_clk(link.prog_clk), .serial_parallel_select(link.serial_parallel_select),
        .dev_sel_n(link.dev_sel_n), .apply_n(link.apply_n), .ser_in(link.ser_in),
        .ser_out(link.ser_out), .output_address(link.output_address),
        .par_data(link.par_data), .kill_n(link.kill_n));

    // Free-running system clock.
    initial begin
        clk_i = 1'b0;
        forever #12.5 clk_i = ~clk_i;
    end

    // Decoded enables: the enable sits in the low bit of each slot.
    function automatic logic [7:0] exp_en(input logic [31:0] w);
        exp_en = 8'h00;
        for (int k = 0; k < 8; k++) exp_en[k] = w[4*k];
    endfunction : exp_en

    // Decoded sources: source bit 0 is the high bit of a slot; zero while disabled.
    function automatic logic [23:0] exp_src(input logic [31:0] w);
        exp_src = 24'h000000;
        for (int k = 0; k < 8; k++) begin
            if (w[4*k]) exp_src[3*k +: 3] = {w[4*k+1], w[4*k+2], w[4*k+3]};
        end
    endfunction : exp_src

    // Compares one value and counts the result.
    task automatic check(input string name, input logic [31:0] e, input logic [31:0] g);
        tests_run++;
        if (g !== e) begin
            $display("ERROR %s expected %h seen %h", name, e, g);
            err_count++;
        end
    endtask : check

    // One classic cycle; the request stands until ack is seen at a rising edge.
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q);
        int n;
        n = 0;
        @(posedge clk_i);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        sel <= 4'hf;
        adr <= a;
        wdat <= d;
        // Ack and data are read at the rising edge, before that edge moves them.
        do begin
            @(posedge clk_i);
            n++;
        end while (ack_o !== 1'b1 && n < 20);
        if (n >= 20) check("ack", 32'h1, 32'h0);
        q = dat_o;
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
        sel <= 4'h0;
    endtask : wb

    // Polls the busy flag under a bounded count.
    task automatic wait_idle();
        logic [31:0] s;
        int n;
        n = 0;
        do begin
            wb(1'b0, `XPP_REG_CMD, 32'h0, s);
            n++;
        end while (s[0] !== 1'b0 && n < 200);
        if (n >= 200) check("idle", 32'h0, s);
    endtask : wait_idle

    // Issues one command and waits until the link is idle again.
    task automatic cmd(input logic [31:0] c);
        wb(1'b1, `XPP_REG_CMD, c, r);
        wait_idle();
    endtask : cmd

    // Compares the switch controls with the decode of a word.
    task automatic route_chk(input logic [31:0] w);
        check("route_en", {24'h000000, exp_en(w)}, {24'h000000, route_en});
        check("route_src", {8'h00, exp_src(w)}, {8'h00, route_src});
    endtask : route_chk

    // Prints the counts and the verdict, then ends the run.
    task automatic test_done();
        $display("checks %0d mismatches %0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : test_done

    // Watchdog: the whole sequence needs well under this span.
    initial begin
        #200000;
        check("watchdog", 32'h0, 32'h1);
        test_done();
    end

    // Main sequence.
    initial begin
        err_count = 0;
        tests_run = 0;
        // Non-blocking, so the device's reset process is already waiting for the edge.
        rst_i <= 1'b1;
        {cyc, stb, we, sel, adr, wdat} <= '0;
        w1 = 32'h9b3c_e571;
        w2 = 32'h2468_ace1;
        pv[0] = 8'he5;
        pv[1] = 8'h72;
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        wb(1'b0, `XPP_REG_WORD, 32'h0, r);
        check("word", `XPP_WORD_RST, r);
        wb(1'b0, `XPP_REG_PAR, 32'h0, r);
        check("par", {24'h000000, `XPP_PAR_RST}, r);
        wb(1'b0, 8'h14, 32'h0, r);
        check("unmapped", 32'h0, r);
        route_chk(32'h0);
        // Serial load with the latch held, then apply.
        wb(1'b1, `XPP_REG_WORD, w1, r);
        wb(1'b1, `XPP_REG_CMD, 32'h1, r);
        wb(1'b0, `XPP_REG_CMD, 32'h0, r);
        check("busy", 32'h1, {31'h0, r[0]});
        wait_idle();
        route_chk(32'h0);
        wb(1'b0, `XPP_REG_RDBK, 32'h0, r);
        check("rdbk0", 32'h0, r);
        cmd(32'h4);
        route_chk(w1);
        // Second load; an apply issued while busy is refused.
        wb(1'b1, `XPP_REG_WORD, w2, r);
        wb(1'b1, `XPP_REG_CMD, 32'h1, r);
        wb(1'b1, `XPP_REG_CMD, 32'h4, r);
        wait_idle();
        route_chk(w1);
        wb(1'b0, `XPP_REG_RDBK, 32'h0, r);
        check("rdbk1", w1, r);
        cmd(32'h4);
        route_chk(w2);
        // Parallel loads rewrite one slot each, enabled and disabled.
        ex = w2;
        foreach (pv[i]) begin
            wb(1'b1, `XPP_REG_PAR, {24'h000000, pv[i]}, r);
            cmd(32'h2);
            ex[4*pv[i][2:0] +: 4] = {pv[i][4], pv[i][5], pv[i][6], pv[i][7]};
            cmd(32'h4);
            route_chk(ex);
        end
        // Kill disables every output and keeps the programming.
        wb(1'b1, `XPP_REG_CTRL, 32'h1, r);
        check("kill_en", 32'h0, {24'h000000, route_en});
        check("kill_src", {8'h00, exp_src(ex)}, {8'h00, route_src});
        wb(1'b1, `XPP_REG_CTRL, 32'h0, r);
        route_chk(ex);
        test_done();
    end
endmodule : tb

// *** testbench/xpp_link_monitor.sv ***
// Checker of the programming link between the controller and the crosspoint device.
`timescale 1ns/1ps
module xpp_link_monitor (
    input  wire logic       clk_i,                  // System clock.
    input  wire logic       rst_i,                  // Synchronous reset, active high.
    input  wire logic       prog_clk,               // Programming clock.
    input  wire logic       serial_parallel_select, // Low for serial loading.
    input  wire logic       dev_sel_n,              // Device select, active low.
    input  wire logic       apply_n,                // Latch control, active low.
    input  wire logic       ser_in,                 // Serial data into the device.
    input  wire logic       ser_out,                // Serial data out of the device.
    input  wire logic [2:0] output_address,         // Slot address.
    input  wire logic [3:0] par_data,               // Parallel slot data.
    input  wire logic       kill_n                  // Output kill, active low.
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    logic        pclk_q;   // Link clock one system cycle ago.
    logic [5:0]  fall_cnt; // Falling edges within one select burst.
    logic        last_ser; // Mode at the last falling edge, 1 for serial.
    logic [31:0] mirror;   // Expected content of the device shift register.
    logic        fall;     // A selected falling edge happened in the last cycle.

    assign fall = pclk_q && !prog_clk && !dev_sel_n;

    // The mirror is updated one cycle after each falling edge, when the device has settled.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pclk_q   <= 1'b1;
            fall_cnt <= 6'h00;
            last_ser <= 1'b0;
            mirror   <= 32'h0000_0000;
        end else begin
            pclk_q <= prog_clk;
            if (dev_sel_n) begin
                fall_cnt <= 6'h00;
            end else if (fall) begin
                fall_cnt <= fall_cnt + 6'h01;
            end
            if (fall) begin
                last_ser <= !serial_parallel_select;
                if (!serial_parallel_select) begin
                    mirror <= {mirror[30:0], ser_in};
                end else begin
                    mirror[4*output_address +: 4] <= {par_data[0], par_data[1],
                                                      par_data[2], par_data[3]};
                end
            end
        end
    end

    property p_sel_clk;
        $fell(prog_clk) |-> !dev_sel_n;
    endproperty
    a_sel_clk: assert property (p_sel_clk) else $error("clock fell without select");

    property p_apply_hold;
        $fell(prog_clk) |-> apply_n;
    endproperty
    a_apply_hold: assert property (p_apply_hold) else $error("latch open while clocking");

    property p_clk_low;
        $fell(prog_clk) |-> !prog_clk [*4] ##1 prog_clk;
    endproperty
    a_clk_low: assert property (p_clk_low) else $error("link clock low phase wrong");

    property p_pins_stable;
        $fell(prog_clk) |-> $stable(ser_in) && $stable(serial_parallel_select)
            && $stable(output_address) && $stable(par_data);
    endproperty
    a_pins_stable: assert property (p_pins_stable) else $error("pins moved at edge");

    property p_apply_pulse;
        $fell(apply_n) |-> (!apply_n && !dev_sel_n) [*4] ##1 (apply_n && !dev_sel_n);
    endproperty
    a_apply_pulse: assert property (p_apply_pulse) else $error("apply pulse wrong");

    property p_bit_count;
        $rose(dev_sel_n) && last_ser && fall_cnt != 6'h00 |-> fall_cnt == 6'h20;
    endproperty
    a_bit_count: assert property (p_bit_count) else $error("serial burst not 32 bits");

    property p_par_count;
        $rose(dev_sel_n) && !last_ser && fall_cnt != 6'h00 |-> fall_cnt == 6'h01;
    endproperty
    a_par_count: assert property (p_par_count) else $error("parallel load not one edge");

    property p_ser_out;
        fall && !serial_parallel_select |-> ser_out == mirror[30];
    endproperty
    a_ser_out: assert property (p_ser_out) else $error("serial out wrong");

    c_serial: cover property (fall && !serial_parallel_select);
    c_parallel: cover property (fall && serial_parallel_select);
    c_apply: cover property ($fell(apply_n));
    c_kill: cover property (!kill_n);
endmodule : xpp_link_monitor

// *** verilog/xpp_cfg.svh ***
// Constants of the crosspoint programming port: offsets, fields, resets, timing.
`ifndef XPP_CFG_SVH
`define XPP_CFG_SVH

// Shift register geometry: eight outputs, one 4-bit slot each.
`define XPP_SR_BITS        32
`define XPP_OUTPUTS        8
`define XPP_SLOT_BITS      4
`define XPP_SRC_BITS       3

// Controller register byte offsets on the Wishbone bus.
`define XPP_REG_WORD       8'h00
`define XPP_REG_PAR        8'h04
`define XPP_REG_CMD        8'h08
`define XPP_REG_CTRL       8'h0c
`define XPP_REG_RDBK       8'h10

// Field positions of the command, status, control and slot registers.
`define XPP_CMD_SHIFT      0
`define XPP_CMD_PAR        1
`define XPP_CMD_APPLY      2
`define XPP_STAT_BUSY      0
`define XPP_CTRL_KILL      0
`define XPP_PAR_ADDR_LSB   0
`define XPP_PAR_SRC_LSB    4
`define XPP_PAR_ON         7

// Reset values of the controller registers.
`define XPP_WORD_RST       32'h0000_0000
`define XPP_PAR_RST        8'h00
`define XPP_KILL_RST       1'b0

// Timing: link clock period and system clock period in ns, half period in cycles.
`define XPP_LINK_PERIOD_NS 160
`define XPP_CLK_PERIOD_NS  25
`define XPP_LINK_HALF_CYC  ((`XPP_LINK_PERIOD_NS / 2 + `XPP_CLK_PERIOD_NS - 1) / `XPP_CLK_PERIOD_NS)

`endif

// *** verilog/xpp_dev.sv ***
// Device end: shift register, update latch and output decode of the crosspoint.
`timescale 1ns/1ps
`include "xpp_cfg.svh"
module xpp_dev
    import xpp_pkg::*;
(
    input  wire logic        rst_i,          // Clears register and latch, disables outputs.
    xpp_link_if.dev          link,           // Programming pins.
    output logic [7:0]       route_enable_o, // One enable per output.
    output logic [23:0]      route_source_o  // Three source bits per output.
);

    xpp_dev_s    s;       // Registered state.
    xpp_dev_s    next_s;  // Next state.
    logic [31:0] applied; // Word held by the update latch.
    logic        latch_open; // Latch transparency.

    // Next shift register value; nothing changes while the device is not selected.
    always_comb begin
        next_s = s;
        if (!link.dev_sel_n) begin // R2
            if (!link.serial_parallel_select) begin // R1
                // Shift toward bit 31 so each bit leaves after 32 falling edges.
                next_s.sr = {s.sr[`XPP_SR_BITS-2:0], link.ser_in}; // R16
            end else begin
                // Slot bits run D0 at the top down to the enable bit at the bottom.
                next_s.sr[{link.output_address, 2'b00} +: `XPP_SLOT_BITS] =
                    {link.par_data[0], link.par_data[1], link.par_data[2],
                     link.par_data[3]}; // R15 R17
            end
        end
    end

    // The register moves on the falling link clock edge; the clock may stand still,
    // so reset cannot wait for an edge and acts at once.
    always_ff @(negedge link.prog_clk or posedge rst_i) begin // R6
        if (rst_i) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign link.ser_out = s.sr[`XPP_SR_BITS-1]; // R12

    // Transparent while selected and apply is low, so any shifting shows through.
    assign latch_open = !link.apply_n && !link.dev_sel_n;

    // Asynchronous update latch between register and switch array.
    always_latch begin
        if (rst_i) begin
            applied = '0;
        end else if (latch_open) begin // R11 R5
            applied = s.sr;
        end
    end

    // Per-output decode; the kill pin gates enables without touching stored data.
    genvar k;
    generate
        for (k = 0; k < `XPP_OUTPUTS; k = k + 1) begin : g_out
            assign route_enable_o[k] = applied[4*k] && link.kill_n; // R8 R18 R19
            // An output with its enable bit clear routes nothing, so its source bits read zero.
            assign route_source_o[3*k +: 3] = applied[4*k] ?
                {applied[4*k+1], applied[4*k+2], applied[4*k+3]} : 3'h0; // R9 R19
        end
    endgenerate

endmodule : xpp_dev

// *** verilog/xpp_host.sv ***
// Controller end: Wishbone registers driving the crosspoint programming pins.
`timescale 1ns/1ps
`include "xpp_cfg.svh"
// Operation
// [R1] Drive mode select low for serial shifting
// [R2] Device loads only while its select low
// [R3] Individual select picks device on shared lines
// [R4] Hold apply high while shifting serial data
// [R5] Low apply during shift passes every state
// [R6] Device shifts on each falling clock edge
// [R7] Shift exactly 32 bits before applying
// [R8] Slot: three source bits then enable
// [R9] Enable low disables output, ignores source
// [R10] Send highest output slot first
// [R11] Update latch transparent low, holding high
// [R12] Serial out feeds next device's input
// [R13] Chain shares clock, select, apply, mode
// [R14] Chain: last device first, 32 each
// [R15] Parallel load rewrites one output only
// [R16] Bit reappears at serial out after 32
// [R17] Parallel: four bits into addressed slot
// [R18] Kill low disables outputs, keeps data
// [R19] Latched word decodes into eight controls
module xpp_host
    import xpp_pkg::*;
(
    input  wire logic        clk_i,   // System clock.
    input  wire logic        rst_i,   // Synchronous reset, active high.
    input  wire logic        cyc_i,   // Wishbone cycle.
    input  wire logic        stb_i,   // Wishbone strobe.
    input  wire logic        we_i,    // Wishbone write enable.
    input  wire logic [7:0]  adr_i,   // Wishbone byte address.
    input  wire logic [3:0]  sel_i,   // Wishbone byte enables.
    input  wire logic [31:0] dat_i,   // Wishbone write data.
    output logic [31:0]      dat_o,   // Wishbone read data.
    output logic             ack_o,   // Wishbone acknowledge.
    xpp_link_if.host         link     // Programming pins.
);

    localparam logic [2:0] HALF_LAST = 3'(`XPP_LINK_HALF_CYC - 1); // Last count of a half.

    xpp_host_s s;      // Registered state.
    xpp_host_s next_s; // Next state.
    logic      req;    // New bus request this cycle.
    logic      busy;   // A link transfer is under way.

    assign req  = cyc_i && stb_i && !s.ack;
    assign busy = (s.st != XPP_IDLE);

    // Sequencer and register file in one next-state process.
    always_comb begin
        next_s     = s;
        next_s.ack = 1'b0;
        // Two flops before the serial return is used anywhere.
        next_s.so_meta = link.ser_out;
        next_s.so_sync = s.so_meta;

        // Link sequencer: the clock is made here by counting half periods.
        case (s.st)
            XPP_IDLE: begin
                // Select falls back only after clock and apply are settled.
                next_s.dsel_n = 1'b1;
            end
            XPP_HIGH: begin
                next_s.cnt = s.cnt + 3'h1;
                if (s.cnt == HALF_LAST) begin
                    next_s.cnt      = 3'h0;
                    next_s.prog_clk = 1'b0; // R6
                    if (s.op == XPP_OP_SHIFT) begin
                        // Catch the bit being pushed out, for readback or checking.
                        next_s.rdbk = {s.rdbk[30:0], s.so_sync}; // R12
                    end
                    next_s.st = XPP_LOW;
                end
            end
            XPP_LOW: begin
                next_s.cnt = s.cnt + 3'h1;
                if (s.cnt == HALF_LAST) begin
                    next_s.cnt      = 3'h0;
                    next_s.prog_clk = 1'b1;
                    if (s.op == XPP_OP_SHIFT && s.bit_idx != 5'h0) begin
                        // Data changes on the rising edge, half a period before use.
                        next_s.bit_idx = s.bit_idx - 5'h1;
                        next_s.sdi     = s.word[s.bit_idx - 5'h1]; // R10
                        next_s.st      = XPP_HIGH;
                    end else begin
                        next_s.st = XPP_IDLE; // R7
                    end
                end
            end
            XPP_APPLY: begin
                next_s.cnt = s.cnt + 3'h1;
                if (s.cnt == HALF_LAST) begin
                    next_s.cnt     = 3'h0;
                    next_s.apply_n = 1'b1; // R11
                    next_s.st      = XPP_IDLE;
                end
            end
            default: begin
                next_s.st = XPP_IDLE;
            end
        endcase

        // Wishbone slave: answer every request one cycle later.
        if (req) begin
            next_s.ack = 1'b1;
            next_s.dat = 32'h0000_0000;
            if (we_i) begin
                case (adr_i)
                    `XPP_REG_WORD: begin
                        for (int b = 0; b < 4; b++) begin
                            if (sel_i[b]) begin
                                next_s.word[8*b +: 8] = dat_i[8*b +: 8];
                            end
                        end
                    end
                    `XPP_REG_PAR: begin
                        if (sel_i[0]) begin
                            next_s.par = dat_i[7:0];
                        end
                    end
                    `XPP_REG_CTRL: begin
                        if (sel_i[0]) begin
                            next_s.kill = dat_i[`XPP_CTRL_KILL]; // R18
                        end
                    end
                    `XPP_REG_CMD: begin
                        // Commands while busy are dropped; software polls status.
                        if (sel_i[0] && !busy) begin
                            if (dat_i[`XPP_CMD_SHIFT]) begin
                                next_s.op       = XPP_OP_SHIFT;
                                next_s.st       = XPP_HIGH;
                                next_s.cnt      = 3'h0;
                                next_s.bit_idx  = 5'h1f; // R7 R14
                                next_s.dsel_n   = 1'b0; // R2 R3
                                next_s.sps      = 1'b0; // R1
                                next_s.apply_n  = 1'b1; // R4
                                next_s.sdi      = s.word[`XPP_SR_BITS-1]; // R10
                                next_s.prog_clk = 1'b1;
                            end else if (dat_i[`XPP_CMD_PAR]) begin
                                next_s.op       = XPP_OP_PAR;
                                next_s.st       = XPP_HIGH;
                                next_s.cnt      = 3'h0;
                                next_s.dsel_n   = 1'b0; // R2
                                next_s.sps      = 1'b1; // R15
                                next_s.apply_n  = 1'b1;
                                next_s.addr     = s.par[`XPP_PAR_ADDR_LSB +: 3]; // R17
                                next_s.pdata    = {s.par[`XPP_PAR_ON],
                                                   s.par[`XPP_PAR_SRC_LSB +: 3]}; // R8
                                next_s.prog_clk = 1'b1;
                            end else if (dat_i[`XPP_CMD_APPLY]) begin
                                // Apply is a separate order so a chain can be filled first.
                                next_s.op      = XPP_OP_APPLY;
                                next_s.st      = XPP_APPLY;
                                next_s.cnt     = 3'h0;
                                next_s.dsel_n  = 1'b0;
                                next_s.apply_n = 1'b0; // R13 R14
                            end
                        end
                    end
                    default: begin
                        // Unmapped writes are acknowledged and dropped.
                    end
                endcase
            end else begin
                case (adr_i)
                    `XPP_REG_WORD: next_s.dat = s.word;
                    `XPP_REG_PAR:  next_s.dat = {24'h00_0000, s.par};
                    `XPP_REG_CMD:  next_s.dat = {31'h0000_0000, busy};
                    `XPP_REG_CTRL: next_s.dat = {31'h0000_0000, s.kill};
                    `XPP_REG_RDBK: next_s.dat = s.rdbk;
                    default:       next_s.dat = 32'h0000_0000;
                endcase
            end
        end
    end

    // State register; reset parks the link idle with every control inactive.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            s          <= '0;
            s.st       <= XPP_IDLE;
            s.op       <= XPP_OP_SHIFT;
            s.word     <= `XPP_WORD_RST;
            s.par      <= `XPP_PAR_RST;
            s.kill     <= `XPP_KILL_RST;
            s.prog_clk <= 1'b1;
            s.dsel_n   <= 1'b1;
            s.apply_n  <= 1'b1;
        end else begin
            s <= next_s;
        end
    end

    // All pins come from flops; kill_n passes through one inverter.
    assign dat_o                       = s.dat;
    assign ack_o                       = s.ack;
    assign link.prog_clk               = s.prog_clk;
    assign link.serial_parallel_select = s.sps;
    assign link.dev_sel_n              = s.dsel_n;
    assign link.apply_n                = s.apply_n;
    assign link.ser_in                 = s.sdi;
    assign link.output_address         = s.addr;
    assign link.par_data               = s.pdata;
    assign link.kill_n                 = !s.kill;

endmodule : xpp_host

// *** verilog/xpp_link_if.sv ***
// Programming link between the controller and the crosspoint device.
`timescale 1ns/1ps
interface xpp_link_if;
    logic       prog_clk;               // Programming clock, device acts on falling edge.
    logic       serial_parallel_select; // Low selects serial, high parallel loading.
    logic       dev_sel_n;              // Device select, active low.
    logic       apply_n;                // Update latch control, transparent when low.
    logic       ser_in;                 // Serial data into the device.
    logic       ser_out;                // Serial data out of the device.
    logic [2:0] output_address;         // Slot address in parallel mode.
    logic [3:0] par_data;               // {output_on_bit, source_index} in parallel mode.
    logic       kill_n;                 // Disables all outputs while low.

    // Device end.
    modport dev (
        input  prog_clk, serial_parallel_select, dev_sel_n, apply_n, ser_in,
        input  output_address, par_data, kill_n,
        output ser_out
    );

    // Controller end.
    modport host (
        output prog_clk, serial_parallel_select, dev_sel_n, apply_n, ser_in,
        output output_address, par_data, kill_n,
        input  ser_out
    );
endinterface : xpp_link_if

// *** verilog/xpp_pkg.sv ***
// Types shared by both ends of the crosspoint programming port.
package xpp_pkg;

    // Controller sequencer states, Gray coded along the bit loop.
    typedef enum logic [1:0] {
        XPP_IDLE  = 2'b00,
        XPP_HIGH  = 2'b01,
        XPP_LOW   = 2'b11,
        XPP_APPLY = 2'b10
    } xpp_state_e;

    // Kind of transfer under way in the controller.
    typedef enum logic [1:0] {
        XPP_OP_SHIFT = 2'b00,
        XPP_OP_PAR   = 2'b01,
        XPP_OP_APPLY = 2'b10
    } xpp_op_e;

    // Registered state of the device end: its shift register; the update latch is held apart.
    typedef struct packed {
        logic [31:0] sr;
    } xpp_dev_s;

    // Whole state of the controller end.
    typedef struct packed {
        xpp_state_e  st;
        xpp_op_e     op;
        logic [2:0]  cnt;
        logic [4:0]  bit_idx;
        logic [31:0] word;
        logic [7:0]  par;
        logic        kill;
        logic [31:0] rdbk;
        logic        ack;
        logic [31:0] dat;
        logic        so_meta;
        logic        so_sync;
        logic        prog_clk;
        logic        sps;
        logic        dsel_n;
        logic        apply_n;
        logic        sdi;
        logic [2:0]  addr;
        logic [3:0]  pdata;
    } xpp_host_s;

endpackage : xpp_pkg
